// [verilog/token_host_pkg.sv]
package token_host_pkg;
  localparam int unsigned token_count = 8;
  localparam int unsigned index_width = 3;
  localparam int unsigned addr_width = 14;
  localparam int unsigned data_width = 16;
  localparam logic flag_take = 1'b0;
  localparam logic flag_free = 1'b1;
  localparam int unsigned clock_mhz = 25;
  // access phase times in ns and their cycle counts (least times round up)
  localparam int unsigned strobe_ns = 80;
  localparam int unsigned strobe_cycles = (strobe_ns * clock_mhz + 999) / 1000;
  localparam int unsigned gap_ns = 40;
  localparam int unsigned gap_cycles = (gap_ns * clock_mhz + 999) / 1000;
  localparam int unsigned count_width = 4;
  typedef enum logic [1:0] {op_take, op_give, op_init} op_e;
  typedef struct packed {
    op_e op;
    logic [index_width-1:0] index;
  } request_s;
  typedef struct packed {
    logic array_select_n;
    logic token_space_select_n;
    logic output_enable_n;
    logic write_n;
    logic [addr_width-1:0] addr;
  } pins_s;
endpackage : token_host_pkg

// [verilog/token_host.sv]
`timescale 1ns/1ns
module token_host #(
  parameter int unsigned poll_limit = 16
) (
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic req_valid_i,
  input wire token_host_pkg::request_s req_i,
  output logic req_ready_o,
  output logic done_o,
  output logic granted_o,
  output token_host_pkg::pins_s pins_o,
  output logic [token_host_pkg::data_width-1:0] data_out_o,
  output logic data_oe_o,
  input wire logic [token_host_pkg::data_width-1:0] data_in_i
);
  typedef enum logic [2:0] {s_idle, s_write, s_gap, s_read, s_check, s_done} state_e;
  state_e state;
  state_e next_state;
  token_host_pkg::request_s cur;
  token_host_pkg::request_s next_cur;
  logic [token_host_pkg::count_width-1:0] count;
  logic [token_host_pkg::count_width-1:0] next_count;
  logic [7:0] polls;
  logic [7:0] next_polls;
  logic wbit;
  logic next_wbit;
  logic next_granted;
  logic next_done;
  token_host_pkg::pins_s next_pins;
  logic [token_host_pkg::data_width-1:0] next_data;
  logic next_oe;

  function automatic token_host_pkg::pins_s idle_pins();
    token_host_pkg::pins_s p;
    p.array_select_n = 1'b1;
    p.token_space_select_n = 1'b1;
    p.output_enable_n = 1'b1;
    p.write_n = 1'b1;
    p.addr = '0;
    return p;
  endfunction : idle_pins

  function automatic token_host_pkg::pins_s drive_pins(
      input logic [token_host_pkg::index_width-1:0] idx, input logic rd);
    token_host_pkg::pins_s p;
    p = idle_pins();
    p.token_space_select_n = 1'b0;
    p.output_enable_n = ~rd;
    p.write_n = rd;
    p.addr = {{(token_host_pkg::addr_width-token_host_pkg::index_width){1'b0}}, idx};
    return p;
  endfunction : drive_pins

  localparam logic [token_host_pkg::count_width-1:0] strobe_last =
    token_host_pkg::count_width'(token_host_pkg::strobe_cycles - 1);
  localparam logic [token_host_pkg::count_width-1:0] gap_last =
    token_host_pkg::count_width'(token_host_pkg::gap_cycles - 1);

  always_comb begin
    next_state = state;
    next_cur = cur;
    next_count = count;
    next_polls = polls;
    next_wbit = wbit;
    next_granted = granted_o;
    next_done = 1'b0;
    next_pins = idle_pins();
    // data held after a strobe ends, so the far side never sees it move under select
    next_data = data_out_o;
    next_oe = 1'b0;
    case (state)
      s_idle: begin
        if (req_valid_i) begin
          next_cur = req_i;
          next_count = '0;
          next_polls = '0;
          if (req_i.op == token_host_pkg::op_init) begin
            next_cur.index = '0;
          end
          // zero takes, one releases; init writes one
          next_wbit = (req_i.op == token_host_pkg::op_take) ? token_host_pkg::flag_take
                                                            : token_host_pkg::flag_free;
          next_state = s_write;
        end
      end
      s_write: begin
        // write cycle with select low; data bit 0 carries flag
        next_pins = drive_pins(cur.index, 1'b0);
        next_data = {{(token_host_pkg::data_width-1){1'b0}}, wbit};
        next_oe = 1'b1;
        next_count = count + 1'b1;
        if (count == strobe_last) begin
          next_count = '0;
          next_state = s_gap;
        end
      end
      s_gap: begin
        next_count = count + 1'b1;
        if (count == gap_last) begin
          next_count = '0;
          if (cur.op == token_host_pkg::op_take) begin
            next_state = s_read;
          end else if (cur.op == token_host_pkg::op_init &&
                       cur.index != token_host_pkg::index_width'(token_host_pkg::token_count-1)) begin
            next_cur.index = cur.index + 1'b1;
            next_state = s_write;
          end else begin
            next_state = s_done;
          end
        end
      end
      s_read: begin
        next_pins = drive_pins(cur.index, 1'b1);
        next_count = count + 1'b1;
        if (count == strobe_last) begin
          next_count = '0;
          next_state = s_check;
        end
      end
      s_check: begin
        // zero on bit 0 means token held
        if (data_in_i[0] == token_host_pkg::flag_take) begin
          next_granted = 1'b1;
          next_state = s_done;
        end else if (polls == 8'(poll_limit - 1)) begin
          // withdraw failed request by writing one
          next_cur.op = token_host_pkg::op_give;
          next_wbit = token_host_pkg::flag_free;
          next_granted = 1'b0;
          next_state = s_write;
        end else begin
          next_polls = polls + 1'b1;
          next_state = s_gap;
        end
      end
      s_done: begin
        if (cur.op == token_host_pkg::op_give || cur.op == token_host_pkg::op_init) begin
          next_granted = 1'b0;
        end
        next_done = 1'b1;
        next_state = s_idle;
      end
      default: next_state = s_idle;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= s_idle;
      cur <= '0;
      count <= '0;
      polls <= '0;
      wbit <= 1'b1;
      granted_o <= 1'b0;
      done_o <= 1'b0;
      pins_o <= idle_pins();
      data_out_o <= '0;
      data_oe_o <= 1'b0;
      req_ready_o <= 1'b0;
    end else begin
      state <= next_state;
      cur <= next_cur;
      count <= next_count;
      polls <= next_polls;
      wbit <= next_wbit;
      granted_o <= next_granted;
      done_o <= next_done;
      pins_o <= next_pins;
      data_out_o <= next_data;
      data_oe_o <= next_oe;
      req_ready_o <= (next_state == s_idle);
    end
  end

  chk_array_kept_off: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pins_o.array_select_n) else $error("array select driven low");
  chk_high_addr_zero: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    pins_o.addr[token_host_pkg::addr_width-1:token_host_pkg::index_width] == '0)
    else $error("high address bits set");
  chk_read_release: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (!pins_o.output_enable_n && $past(state) == s_read && state == s_check)
    |=> pins_o.token_space_select_n) else $error("no release between reads");
  chk_write_first: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == s_read) |-> (cur.op == token_host_pkg::op_take))
    else $error("read without take");
  // write drives data only while write low
  chk_write_data: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    data_oe_o |-> (!pins_o.write_n && !pins_o.token_space_select_n
    && data_out_o[token_host_pkg::data_width-1:1] == '0)) else $error("bad write drive");
  // output enable and write never both low
  chk_no_fight: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    !(!pins_o.output_enable_n && !pins_o.write_n)) else $error("read and write together");
  chk_withdraw_one: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == s_check && data_in_i[0] && polls == 8'(poll_limit - 1))
    |=> (state == s_write && wbit == token_host_pkg::flag_free)) else $error("no withdraw");
  chk_init_one: assert property (@(posedge clock_i) disable iff (!rst_n_i)
    (state == s_write && cur.op == token_host_pkg::op_init) |-> wbit)
    else $error("init wrote zero");
  cov_take_ok: cover property (@(posedge clock_i) state == s_check && !data_in_i[0]);
  cov_take_fail: cover property (@(posedge clock_i) state == s_check && data_in_i[0]);
  cov_init_done: cover property (@(posedge clock_i) done_o && cur.op == token_host_pkg::op_init);
endmodule : token_host

// [tb/token_device_model.sv]
`timescale 1ns/1ns
module token_device_model (
  input wire token_host_pkg::pins_s pins_i,
  input wire logic [token_host_pkg::data_width-1:0] data_i,
  input wire logic data_oe_i,
  output logic [token_host_pkg::data_width-1:0] data_o
);
  logic [7:0] req_l = 8'h00;
  logic [7:0] req_r = 8'hff;
  logic [7:0] own_l = 8'hff;
  logic [7:0] own_r = 8'h00;
  logic [token_host_pkg::data_width-1:0] q = '0;
  logic [2:0] wix;
  logic wd;
  wire wr = !pins_i.token_space_select_n && !pins_i.write_n && data_oe_i;
  wire rd = !pins_i.token_space_select_n && !pins_i.output_enable_n;
  // owner keeps, pending side takes over, left wins ties
  task automatic settle(input int i);
    if (own_l[i] && req_l[i]) own_l[i] = 1'b0;
    if (own_r[i] && req_r[i]) own_r[i] = 1'b0;
    if (!own_l[i] && !own_r[i]) begin
      if (!req_l[i]) own_l[i] = 1'b1;
      else if (!req_r[i]) own_r[i] = 1'b1;
    end
  endtask : settle
  task automatic right_write(input int i, input logic b);
    req_r[i] = b;
    settle(i);
  endtask : right_write
  // low three address bits and data bit 0
  always @* if (wr) begin
    wix = pins_i.addr[2:0];
    wd = data_i[0];
  end
  // write lands at end of strobe
  always @(negedge wr) begin
    req_l[wix] = wd;
    settle(wix);
  end
  // flag spread and frozen while read stays active
  always @(posedge rd) q = {token_host_pkg::data_width{!own_l[pins_i.addr[2:0]]}};
  always @* data_o = rd ? q : ~q;
endmodule : token_device_model

// [tb/dual_port_semaphore_flags_test.sv]
`timescale 1ns/1ns
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin miscompares++; \
  $display("mismatch %0t %s", $time, m); end end
module dual_port_semaphore_flags_test;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic req_valid_i = 1'b0;
  token_host_pkg::request_s req_i = '0;
  logic req_ready_o, done_o, granted_o, data_oe_o;
  token_host_pkg::pins_s pins_o;
  logic [token_host_pkg::data_width-1:0] data_out_o, data_in_i;
  int miscompares = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'hfd38;
  token_host #(.poll_limit(2)) DUT (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .req_valid_i(req_valid_i), .req_i(req_i), .req_ready_o(req_ready_o), .done_o(done_o),
    .granted_o(granted_o), .pins_o(pins_o), .data_out_o(data_out_o), .data_oe_o(data_oe_o),
    .data_in_i(data_in_i));
  token_device_model model (.pins_i(pins_o), .data_i(data_out_o), .data_oe_i(data_oe_o),
    .data_o(data_in_i));
  initial forever #20 clock_i = ~clock_i;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : final_report
  task automatic do_op(input token_host_pkg::op_e op, input logic [2:0] i);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && n < 50) begin @(negedge clock_i); n++; end
    if (n >= 50) begin miscompares++; final_report(); end
    req_i.op = op;
    req_i.index = i;
    req_valid_i = 1'b1;
    @(negedge clock_i);
    req_valid_i = 1'b0;
    while (done_o !== 1'b1 && n < 400) begin @(negedge clock_i); n++; end
    if (n >= 400) begin miscompares++; final_report(); end
  endtask : do_op
  always @(negedge clock_i) if (rst_n_i && pins_o.token_space_select_n === 1'b0)
    `CHK(pins_o.array_select_n, 1'b1, "array select low")
  initial begin
    logic [2:0] i;
    logic rh;
    repeat (10) @(negedge clock_i);
    rst_n_i = 1'b1;
    for (int k = 0; k < 8; k++) model.right_write(k, 1'b1);
    do_op(token_host_pkg::op_init, 3'h0);
    for (int k = 0; k < 8; k++) `CHK(model.req_l[k] & !model.own_l[k], 1'b1, "init")
    $display("test init done");
    for (int t = 0; t < 24; t++) begin
      i = 3'(rnd());
      rh = 1'(rnd() >> 7);
      model.right_write(i, !rh);
      do_op(token_host_pkg::op_take, i);
      `CHK(granted_o, !rh, "take result")
      `CHK(model.req_l[i], rh, "failed take not withdrawn")
      `CHK(model.own_r[i], rh, "owner lost token")
      model.right_write(i, 1'b1);
      do_op(token_host_pkg::op_give, i);
      `CHK(granted_o, 1'b0, "give left grant")
      `CHK(model.own_l[i] | model.own_r[i], 1'b0, "token not free")
    end
    $display("test random take give done");
    model.right_write(3'h5, 1'b0);
    fork
      do_op(token_host_pkg::op_take, 3'h5);
      begin repeat (6) @(negedge clock_i); model.right_write(3'h5, 1'b1); end
    join
    `CHK(granted_o, 1'b1, "pending request not passed")
    do_op(token_host_pkg::op_give, 3'h5);
    `CHK(model.own_l[5], 1'b0, "release after pass")
    $display("test pending pass done");
    final_report();
  end
endmodule : dual_port_semaphore_flags_test
